/* File: verilog/dmatm_channel.sv */
// One DMA channel: transfer-mode decode and cycle sequencing
`timescale 1ns/1ps
// Functional notes
// - Mode comes from the low three bits of the fetched control word.
// - Mode zero means stopped or invalid; no transfers happen.
// - Basic mode needs a new request before every arbitration entry.
// - Auto-request mode moves the whole item count after one request.
// - Ping-pong runs cycles alternately from primary and alternate structures.
// - Ping-pong ends on an invalid structure or a change to any mode other than ping-pong.
module dmatm_channel #(
    parameter int unsigned CNT_W = dmatm_pkg::ITEM_CNT_W
) (
    // Clock and reset
    input  wire logic                              clk_sys_i,
    input  wire logic                              reset_i,
    // Channel requests
    input  wire logic                              req_i,
    input  wire logic                              sw_req_i,
    // Control word fetch
    output logic                                   fetch_o,
    output logic                                   alt_sel_o,
    input  wire logic                              word_valid_i,
    input  wire logic [dmatm_pkg::CTRL_W-1:0]      ctrl_word_i,
    // Transfer and status
    output logic                                   xfer_o,
    output logic                                   done_o,
    output logic                                   stopped_o,
    output logic [dmatm_pkg::MODE_W-1:0]           mode_o,
    output logic [CNT_W:0]                         remaining_o
);
    import dmatm_pkg::*;

    localparam logic [CNT_W:0] ONE_ITEM = {{CNT_W{1'b0}}, 1'b1};

    dmatm_state_e          state_q;
    dmatm_state_e          state_d;
    logic                  first_q;
    logic                  first_d;
    logic                  each_q;
    logic                  pp_q;
    logic                  alt_q;
    logic                  alt_d;
    logic                  stopped_q;
    logic                  fetch_q;
    logic                  xfer_q;
    logic                  done_q;
    logic [MODE_W-1:0]     mode_q;
    logic [CNT_W:0]        remaining_q;
    logic [CNT_W:0]        remaining_d;

    wire                   req_any;
    wire [MODE_W-1:0]      word_mode;
    wire [CNT_W:0]         word_count;
    wire                   w_stop;
    wire                   w_each;
    wire                   w_pp;
    wire                   last_item;
    wire                   word_take;

    assign req_any    = req_i | sw_req_i;
    assign word_mode  = ctrl_word_i[MODE_LSB +: MODE_W];
    // Field holds count minus one
    assign word_count = {1'b0, ctrl_word_i[ITEM_LSB +: CNT_W]} + ONE_ITEM;
    assign last_item  = (remaining_q == ONE_ITEM);
    assign word_take  = (state_q == ST_FETCH) && word_valid_i;

    dmatm_mode_dec u_dec (
        .mode_i     (word_mode),
        .stop_o     (w_stop),
        .each_req_o (w_each),
        .pingpong_o (w_pp)
    );

    always_comb begin
        state_d     = state_q;
        first_d     = first_q;
        alt_d       = alt_q;
        remaining_d = remaining_q;
        case (state_q)
            ST_IDLE: begin
                if (req_any) begin
                    state_d = ST_FETCH;
                    first_d = 1'b1;
                end
            end
            ST_FETCH: begin
                if (word_valid_i) begin
                    if (w_stop) begin
                        state_d = ST_IDLE;
                        alt_d   = SEL_PRIMARY;
                    end else begin
                        remaining_d = word_count;
                        // A follow-on cycle waits for its own request
                        state_d     = first_q ? ST_ARB : ST_WAIT;
                    end
                end
            end
            ST_ARB: begin
                remaining_d = remaining_q - ONE_ITEM;
                if (last_item) begin
                    state_d = ST_DONE;
                end else if (each_q) begin
                    state_d = ST_WAIT;
                end else begin
                    state_d = ST_ARB;
                end
            end
            ST_WAIT: begin
                if (req_any) begin
                    state_d = ST_ARB;
                end
            end
            ST_DONE: begin
                if (pp_q) begin
                    state_d = ST_FETCH;
                    alt_d   = ~alt_q;
                    first_d = 1'b0;
                end else begin
                    state_d = ST_IDLE;
                    alt_d   = SEL_PRIMARY;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q     <= ST_IDLE;
            first_q     <= 1'b0;
            alt_q       <= SEL_PRIMARY;
            remaining_q <= '0;
        end else begin
            state_q     <= state_d;
            first_q     <= first_d;
            alt_q       <= alt_d;
            remaining_q <= remaining_d;
        end
    end

    // Mode flags latch only on a fetched word, so a stale word in RAM cannot steer a live cycle
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mode_q    <= MODE_STOP;
            each_q    <= 1'b0;
            pp_q      <= 1'b0;
            stopped_q <= 1'b1;
        end else if (word_take) begin
            mode_q    <= word_mode;
            each_q    <= w_each;
            pp_q      <= w_pp;
            stopped_q <= w_stop;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            fetch_q <= 1'b0;
            xfer_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            fetch_q <= (state_d == ST_FETCH);
            xfer_q  <= (state_q == ST_ARB);
            done_q  <= (state_q == ST_DONE);
        end
    end

    assign fetch_o     = fetch_q;
    assign alt_sel_o   = alt_q;
    assign xfer_o      = xfer_q;
    assign done_o      = done_q;
    assign stopped_o   = stopped_q;
    assign mode_o      = mode_q;
    assign remaining_o = remaining_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    sequence s_take_stop;
        word_take && w_stop;
    endsequence

    sequence s_take_go;
        word_take && !w_stop;
    endsequence

    mode_latch_a: assert property (word_take |=> mode_o == $past(word_mode))
        else $error("mode not taken from low bits of control word");

    stop_no_xfer_a: assert property (s_take_stop |=> stopped_o && state_q == ST_IDLE ##1 !xfer_o)
        else $error("stopped channel went on to transfer");

    go_clears_stop_a: assert property (s_take_go |=> !stopped_o && remaining_o == $past(word_count))
        else $error("valid word did not load count or clear stop");

    basic_wait_a: assert property (state_q == ST_WAIT && !req_any |=> state_q == ST_WAIT)
        else $error("arbitration entered without a fresh request");

    basic_pause_a: assert property (state_q == ST_ARB && each_q && !last_item |=> state_q == ST_WAIT)
        else $error("request-driven mode did not pause after an item");

    auto_stream_a: assert property (state_q == ST_ARB && !each_q && !last_item
                                    |=> state_q == ST_ARB && remaining_o == $past(remaining_q) - ONE_ITEM)
        else $error("auto-request stalled before item count reached");

    pingpong_swap_a: assert property (state_q == ST_DONE && pp_q
                                      |=> alt_sel_o != $past(alt_q) && fetch_o)
        else $error("ping-pong did not switch structure");

    // A request taken in the first idle cycle may start a fresh fetch, so only that cycle is fetch-free
    pingpong_end_a: assert property (state_q == ST_DONE && !pp_q
                                     |=> state_q == ST_IDLE && alt_sel_o == SEL_PRIMARY && !fetch_o)
        else $error("ping-pong continued after mode change");

    pingpong_invalid_a: assert property (s_take_stop |=> alt_sel_o == SEL_PRIMARY && !fetch_o)
        else $error("invalid structure did not end ping-pong");
endmodule : dmatm_channel

/* File: verilog/dmatm_pkg.sv */
// Shared constants and types for the DMA channel transfer-mode sequencer
package dmatm_pkg;
    // Channel control word layout
    localparam int unsigned CTRL_W     = 32;
    localparam int unsigned MODE_LSB   = 0;
    localparam int unsigned MODE_W     = 3;
    localparam int unsigned ITEM_LSB   = 4;
    localparam int unsigned ITEM_CNT_W = 10;

    // Transfer mode codes
    localparam logic [MODE_W-1:0] MODE_STOP       = 3'h0;
    localparam logic [MODE_W-1:0] MODE_BASIC      = 3'h1;
    localparam logic [MODE_W-1:0] MODE_AUTO       = 3'h2;
    localparam logic [MODE_W-1:0] MODE_PINGPONG   = 3'h3;
    localparam logic [MODE_W-1:0] MODE_MEM_SG     = 3'h4;
    localparam logic [MODE_W-1:0] MODE_MEM_SG_ALT = 3'h5;
    localparam logic [MODE_W-1:0] MODE_PER_SG     = 3'h6;
    localparam logic [MODE_W-1:0] MODE_PER_SG_ALT = 3'h7;

    // Structure select values
    localparam logic SEL_PRIMARY = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_ARB,
        ST_WAIT,
        ST_DONE
    } dmatm_state_e;
endpackage : dmatm_pkg

/* File: verilog/dmatm_mode_dec.sv */
// Transfer mode code decoder
`timescale 1ns/1ps
module dmatm_mode_dec (
    // Mode code
    input  wire logic [dmatm_pkg::MODE_W-1:0] mode_i,
    // Decoded behaviour
    output logic                              stop_o,
    output logic                              each_req_o,
    output logic                              pingpong_o
);
    import dmatm_pkg::*;

    assign stop_o     = (mode_i == MODE_STOP);
    // Auto-request and memory scatter-gather need only the opening request
    assign each_req_o = (mode_i == MODE_BASIC) || (mode_i == MODE_PINGPONG) ||
                        (mode_i == MODE_PER_SG) || (mode_i == MODE_PER_SG_ALT);
    assign pingpong_o = (mode_i == MODE_PINGPONG);
endmodule : dmatm_mode_dec

/* File: test/dmatm_host_model.sv */
// Host memory model that serves channel control words on fetch
`timescale 1ns/1ps
module dmatm_host_model (
    // Clock
    input  wire logic        clk_sys_i,
    // Words the host placed in memory
    input  wire logic [31:0] prim_word_i,
    input  wire logic [31:0] alt_word_i,
    // Fetch port
    input  wire logic        fetch_i,
    input  wire logic        alt_sel_i,
    output logic             word_valid_o,
    output logic [31:0]      ctrl_word_o
);
    logic [31:0] last_q;
    initial begin
        word_valid_o = 1'b0;
        ctrl_word_o  = 32'h0000_0000;
        last_q       = 32'h0000_0000;
    end
    // Bench writes each structure with the code meant for it before use
    always @(posedge clk_sys_i) begin
        if (fetch_i && !word_valid_o) begin
            word_valid_o <= 1'b1;
            ctrl_word_o  <= alt_sel_i ? alt_word_i : prim_word_i;
            last_q       <= alt_sel_i ? alt_word_i : prim_word_i;
        end else begin
            // Released bus shows garbage so a stale word is never mistaken for data
            word_valid_o <= 1'b0;
            ctrl_word_o  <= ~last_q;
        end
    end
endmodule : dmatm_host_model

/* File: test/tb_top.sv */
// Self-checking testbench for one DMA channel
`timescale 1ns/1ps
module tb_top;
    import dmatm_pkg::*;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, req_i = 1'b0, sw_req_i = 1'b0;
    logic [31:0] prim_w = 32'h0, alt_w = 32'h0, ctrl_word;
    logic word_valid, fetch, alt_sel, xfer, done, stopped;
    logic [2:0] mode;
    logic [10:0] remaining, xfers = 11'h0, dones = 11'h0, x0, d0;
    logic [10:0] fetches = 11'h0, f0;
    logic fetch_prev = 1'b0;
    int fails = 0, samples_checked = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    dmatm_channel i_dmatm_channel (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req_i), .sw_req_i(sw_req_i),
        .fetch_o(fetch), .alt_sel_o(alt_sel), .word_valid_i(word_valid), .ctrl_word_i(ctrl_word), .xfer_o(xfer),
        .done_o(done), .stopped_o(stopped), .mode_o(mode), .remaining_o(remaining));
    dmatm_host_model i_dmatm_host_model (.clk_sys_i(clk_sys_i), .prim_word_i(prim_w), .alt_word_i(alt_w),
        .fetch_i(fetch), .alt_sel_i(alt_sel), .word_valid_o(word_valid), .ctrl_word_o(ctrl_word));
    always @(posedge clk_sys_i) begin
        if (xfer === 1'b1) xfers <= xfers + 11'h1;
        if (done === 1'b1) dones <= dones + 11'h1;
        if (fetch === 1'b1 && fetch_prev !== 1'b1) fetches <= fetches + 11'h1;
        fetch_prev <= fetch;
    end
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic pulse(input logic sw);
        @(posedge clk_sys_i);
        if (sw) sw_req_i <= 1'b1;
        else req_i <= 1'b1;
        @(posedge clk_sys_i);
        req_i    <= 1'b0;
        sw_req_i <= 1'b0;
    endtask : pulse
    task automatic wait_done;
        logic [10:0] d;
        int i;
        d = dones;
        for (i = 0; i < 60 && dones === d; i++) @(posedge clk_sys_i);
        if (dones === d) begin
            fails++;
            $display("BAD %0t no cycle end", $time);
            wrap_up();
        end
        cyc(2);
    endtask : wait_done
    task automatic t_stop;
        prim_w <= 32'hffff_fff8;
        x0 = xfers;
        f0 = fetches;
        pulse(1'b0);
        cyc(10);
        chk(xfers - x0, 11'h0, "stop xfers");
        chk({10'h0, stopped}, 11'h1, "stopped");
        chk({8'h0, mode}, {8'h0, MODE_STOP}, "stop mode");
        chk(fetches - f0, 11'h1, "stop one fetch");
        $display("test stop done");
    endtask : t_stop
    task automatic t_auto;
        prim_w <= 32'h0000_0032;
        x0 = xfers;
        pulse(1'b1);
        wait_done();
        chk(xfers - x0, 11'h4, "auto xfers");
        chk(remaining, 11'h0, "auto remaining");
        chk({8'h0, mode}, {8'h0, MODE_AUTO}, "auto mode");
        $display("test auto done");
    endtask : t_auto
    task automatic t_basic;
        prim_w <= 32'hffff_c011;
        x0 = xfers;
        pulse(1'b0);
        cyc(12);
        chk(xfers - x0, 11'h1, "basic held");
        chk({8'h0, mode}, {8'h0, MODE_BASIC}, "basic mode");
        pulse(1'b0);
        wait_done();
        chk(xfers - x0, 11'h2, "basic xfers");
        $display("test basic done");
    endtask : t_basic
    task automatic t_pingpong;
        prim_w <= 32'h0000_0003;
        alt_w  <= 32'h0000_0001;
        x0 = xfers;
        d0 = dones;
        pulse(1'b0);
        wait_done();
        cyc(6);
        chk({10'h0, alt_sel}, 11'h1, "alt selected");
        pulse(1'b0);
        wait_done();
        chk(xfers - x0, 11'h2, "pp xfers");
        chk(dones - d0, 11'h2, "pp cycles");
        cyc(12);
        chk({10'h0, alt_sel}, 11'h0, "pp ended");
        chk(dones - d0, 11'h2, "no third cycle");
        $display("test pingpong done");
    endtask : t_pingpong
    task automatic t_pp_long;
        prim_w <= 32'h0000_0003;
        alt_w  <= 32'h0000_0003;
        x0 = xfers;
        d0 = dones;
        f0 = fetches;
        pulse(1'b0);
        wait_done();
        chk({10'h0, alt_sel}, 11'h1, "long alt first");
        // Primary cycle is over, so the host may rewrite it before the switch back
        prim_w <= 32'h0000_0012;
        pulse(1'b0);
        wait_done();
        chk({10'h0, alt_sel}, 11'h0, "back to primary");
        pulse(1'b0);
        wait_done();
        chk(xfers - x0, 11'h4, "long xfers");
        chk(dones - d0, 11'h3, "long cycles");
        chk(fetches - f0, 11'h3, "long fetches");
        chk({8'h0, mode}, {8'h0, MODE_AUTO}, "long ends auto");
        $display("test pingpong long done");
    endtask : t_pp_long
    task automatic t_sg_prim;
        prim_w <= 32'h0000_0014;
        x0 = xfers;
        pulse(1'b1);
        wait_done();
        chk(xfers - x0, 11'h2, "mem sg xfers");
        chk({8'h0, mode}, {8'h0, MODE_MEM_SG}, "mem sg mode");
        prim_w <= 32'h0000_0016;
        x0 = xfers;
        pulse(1'b0);
        cyc(12);
        chk(xfers - x0, 11'h1, "per sg held");
        chk({8'h0, mode}, {8'h0, MODE_PER_SG}, "per sg mode");
        pulse(1'b0);
        wait_done();
        chk(xfers - x0, 11'h2, "per sg xfers");
        $display("test sg primary done");
    endtask : t_sg_prim
    task automatic t_sg_alt;
        prim_w <= 32'h0000_0003;
        alt_w  <= 32'h0000_0017;
        x0 = xfers;
        pulse(1'b0);
        wait_done();
        pulse(1'b0);
        cyc(8);
        chk(xfers - x0, 11'h2, "per sg alt held");
        chk({8'h0, mode}, {8'h0, MODE_PER_SG_ALT}, "per sg alt mode");
        pulse(1'b0);
        wait_done();
        chk(xfers - x0, 11'h3, "per sg alt xfers");
        alt_w  <= 32'h0000_0015;
        x0 = xfers;
        pulse(1'b0);
        wait_done();
        pulse(1'b0);
        wait_done();
        chk(xfers - x0, 11'h3, "mem sg alt xfers");
        chk({8'h0, mode}, {8'h0, MODE_MEM_SG_ALT}, "mem sg alt mode");
        chk({10'h0, alt_sel}, 11'h0, "sg alt ended");
        $display("test sg alternate done");
    endtask : t_sg_alt
    task automatic t_reset;
        prim_w <= 32'h0000_0003;
        alt_w  <= 32'h0000_0011;
        x0 = xfers;
        pulse(1'b0);
        wait_done();
        chk({8'h0, mode}, {8'h0, MODE_BASIC}, "pre reset mode");
        reset_i <= 1'b1;
        cyc(2);
        reset_i <= 1'b0;
        chk({10'h0, stopped}, 11'h1, "mid reset stopped");
        chk({10'h0, alt_sel}, 11'h0, "mid reset primary");
        chk({8'h0, mode}, {8'h0, MODE_STOP}, "mid reset mode");
        chk(remaining, 11'h0, "mid reset remaining");
        chk({10'h0, fetch}, 11'h0, "mid reset fetch");
        prim_w <= 32'h0000_0000;
        cyc(6);
        chk(xfers - x0, 11'h1, "no xfer after reset");
        $display("test reset done");
    endtask : t_reset
    initial begin
        cyc(6);
        reset_i <= 1'b0;
        chk({10'h0, stopped}, 11'h1, "reset stopped");
        t_auto();
        t_stop();
        t_basic();
        t_pingpong();
        t_pp_long();
        t_sg_prim();
        t_sg_alt();
        t_reset();
        wrap_up();
    end
endmodule : tb_top
